// file: rtl/mrf_pkg.sv
package mrf_pkg;

  // ----------------------------------------------------------------
  // Modes and record carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LAYOUT_SEL = 2'h0,
    DEFAULT_LAYOUT_ONE = 2'h1,
    DEFAULT_LAYOUT_TWO = 2'h2
  } mrf_layout_t;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_OVERRANGE = 3'h1,
    ST_OVERFLOW = 3'h2,
    ST_PEAK = 3'h3,
    ST_NODATA = 3'h4
  } mrf_state_t;

  typedef enum logic [1:0] {
    PH_NONE = 2'h0,
    PH_LAG = 2'h1,
    PH_LEAD = 2'h2
  } mrf_phase_t;

  typedef enum logic [1:0] {
    EXP_MILLI = 2'h0,
    EXP_UNIT = 2'h1,
    EXP_KILO = 2'h2,
    EXP_MEGA = 2'h3
  } mrf_exp_t;

  typedef struct packed {
    logic harmonic;
    logic [23:0] dtype;
    logic [2:0] element;
    mrf_state_t state;
    mrf_phase_t phase;
    logic [5:0] order;
    logic negative;
    logic [55:0] mantissa;
    mrf_exp_t expo;
  } mrf_rec_t;

  // ----------------------------------------------------------------
  // Record geometry and line structure
  // ----------------------------------------------------------------
  localparam logic [4:0] HDR_LEN_MEAS = 5'h06;
  localparam logic [4:0] HDR_LEN_HARM = 5'h08;
  localparam logic [4:0] DATA_LEN = 5'h0b;
  localparam logic [5:0] MAX_HARM_ORDER = 6'h32;
  localparam logic [3:0] SEL_SLOTS = 4'h8;
  localparam logic [3:0] SEL_END_LINE = 4'hb;
  localparam logic [3:0] D1_END_LINE = 4'h6;
  localparam logic [3:0] D2I_END_LINE = 4'ha;
  localparam logic [3:0] D2N_END_LINE = 4'h6;
  localparam logic [3:0] SEL_MOTOR_LINE = 4'ha;
  localparam logic [3:0] SEL_INTEG_LAST = 4'h8;
  localparam logic [3:0] D2I_FREQ_LINE = 4'h9;

  // ----------------------------------------------------------------
  // Type codes the formatter must recognise (ASCII)
  // ----------------------------------------------------------------
  localparam logic [23:0] EFFICIENCY_TYPE = 24'h456666;
  localparam logic [23:0] MOTOR_EFFICIENCY_TYPE = 24'h4d4566;
  localparam logic [23:0] TOTAL_EFFICIENCY_TYPE = 24'h544566;
  localparam logic [23:0] ELAPSED_INTEG_TIME_TYPE = 24'h484d20;
  localparam logic [23:0] PHASE_ANGLE_TYPE = 24'h444547;
  localparam logic [23:0] HARMONIC_VOLTAGE_PHASE_TYPE = 24'h444756;
  localparam logic [23:0] HARMONIC_CURRENT_PHASE_TYPE = 24'h444741;

  // ----------------------------------------------------------------
  // Characters and fixed strings
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_PERCENT = 8'h25;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_I = 8'h49;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [23:0] END_WORD = 24'h454e44;
  localparam logic [87:0] OVR_DATA = 88'h20393939393939_2e452b33;
  localparam logic [23:0] EXP_M3 = 24'h452d33;
  localparam logic [23:0] EXP_P0 = 24'h452b30;
  localparam logic [23:0] EXP_P3 = 24'h452b33;
  localparam logic [23:0] EXP_P6 = 24'h452b36;

endpackage : mrf_pkg

// file: rtl/mrf_formatter.sv
`timescale 1ns/1ps

// What this block does
// - Measured records are a six-byte header plus eleven data bytes.
// - Header bytes one to three carry the three-character type code.
// - Header byte four is element 1..3, 4 for sum, or space.
// - Header byte five is the state: N, I, O, P or E.
// - Byte six is G/D/space for phase angle, else space.
// - Data byte one is sign; bytes two to eight the mantissa.
// - Data bytes nine to eleven are E-3, E+0, E+3 or E+6.
// - Efficiency types put percent then two spaces instead of exponent.
// - No-data records copy the overrange pattern with state E.
// - Elapsed time record is hhh:mm:ss in data bytes one to nine.
// - Manual block has eleven lines with END; empty lines are omitted.
// - Disabled items are skipped and later items close up.
// - Manual lines 3,4 need four-wire; 2,4,6,8 integration; 10 motor.
// - First default: V,A,W lines per element and sum, frequency, END.
// - Second default with integration: power, energy lines, freq 9, END 10.
// - Second default without integration: PF lines, freq 5, END 6.
// - Harmonic records are an eight-byte header plus eleven data bytes.
// - Harmonic header bytes one to three carry the quantity type.
// - Harmonic element is 1..3, 4 for totals, space for motor.
// - Harmonic order is 01..50 within the maximum, higher orders skipped; order 0 gives spaces.
// - Harmonic byte eight is lag/lead only for phase types at order 01.
module mrf_formatter (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic START,
  input wire mrf_pkg::mrf_layout_t LAYOUT,
  input wire logic THREE_WIRE,
  input wire logic INTEGRATION_OPTION,
  input wire logic MOTOR_OPTION,
  input wire logic TERM_CRLF,
  input wire logic [5:0] MAX_ORDER,
  input wire logic [79:0] SEL_EN,
  output logic REQ_VALID,
  output logic [3:0] REQ_LINE,
  output logic [3:0] REQ_SLOT,
  input wire logic REC_VALID,
  input wire mrf_pkg::mrf_rec_t REC,
  output logic OUT_VALID,
  output logic [7:0] OUT_DATA,
  input wire logic OUT_READY,
  output logic BUSY,
  output logic DONE
);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_LINE = 3'h1,
    S_SLOT = 3'h2,
    S_REQ = 3'h3,
    S_BYTE = 3'h4,
    S_TERM = 3'h5,
    S_END = 3'h6
  } mrf_fsm_t;

  // ----------------------------------------------------------------
  // Layout tables
  // ----------------------------------------------------------------
  // Decides whether a line of the chosen layout is sent at all
  function automatic logic line_on(mrf_pkg::mrf_layout_t lay,
    logic [3:0] ln, logic three, logic integ, logic motor, logic any);
    logic r;
    r = 1'b1;
    case (lay)
      mrf_pkg::LAYOUT_SEL: begin
        r = any;
        if (three && (ln == 4'h3 || ln == 4'h4)) r = 1'b0;
        if (!integ && !ln[0] && ln <= mrf_pkg::SEL_INTEG_LAST) r = 1'b0;
        if (!motor && ln == mrf_pkg::SEL_MOTOR_LINE) r = 1'b0;
      end
      mrf_pkg::DEFAULT_LAYOUT_ONE: r = !(three && ln == 4'h2);
      mrf_pkg::DEFAULT_LAYOUT_TWO: begin
        if (integ) r = !(three && (ln == 4'h3 || ln == 4'h4));
        else r = !(three && ln == 4'h2);
      end
      default: r = 1'b0;
    endcase
    return r;
  endfunction : line_on

  // Number of item slots on a line
  function automatic logic [3:0] slot_count(mrf_pkg::mrf_layout_t lay,
    logic integ, logic [3:0] ln);
    logic [3:0] n;
    n = 4'h1;
    case (lay)
      mrf_pkg::LAYOUT_SEL: n = mrf_pkg::SEL_SLOTS;
      mrf_pkg::DEFAULT_LAYOUT_ONE: n = (ln <= 4'h4) ? 4'h3 : 4'h1;
      mrf_pkg::DEFAULT_LAYOUT_TWO: begin
        if (integ)
          n = (ln[0] || ln == mrf_pkg::D2I_FREQ_LINE) ? 4'h1 : 4'h7;
        else if (ln <= 4'h3) n = 4'h4;
        else n = (ln == 4'h4) ? 4'h2 : 4'h1;
      end
      default: n = 4'h0;
    endcase
    return n;
  endfunction : slot_count

  // Line number that carries END
  function automatic logic [3:0] end_line(mrf_pkg::mrf_layout_t lay,
    logic integ);
    logic [3:0] n;
    case (lay)
      mrf_pkg::DEFAULT_LAYOUT_ONE: n = mrf_pkg::D1_END_LINE;
      mrf_pkg::DEFAULT_LAYOUT_TWO:
        n = integ ? mrf_pkg::D2I_END_LINE : mrf_pkg::D2N_END_LINE;
      default: n = mrf_pkg::SEL_END_LINE;
    endcase
    return n;
  endfunction : end_line

  // ----------------------------------------------------------------
  // Record byte generator
  // ----------------------------------------------------------------
  function automatic logic [4:0] hdr_len(mrf_pkg::mrf_rec_t r);
    return r.harmonic ? mrf_pkg::HDR_LEN_HARM : mrf_pkg::HDR_LEN_MEAS;
  endfunction : hdr_len

  function automatic logic [7:0] mant_char(mrf_pkg::mrf_rec_t r,
    logic [4:0] k);
    return r.mantissa[8 * (7 - k) +: 8];
  endfunction : mant_char

  // Position 0 is the separating comma, 1.. the record itself
  function automatic logic [7:0] rec_byte(mrf_pkg::mrf_rec_t r,
    logic [4:0] pos);
    logic [4:0] hl;
    logic [4:0] d;
    logic [5:0] tens;
    logic [5:0] ones;
    logic [7:0] b;
    logic [7:0] ph;
    logic [23:0] ex;
    logic pct;
    logic dg;
    hl = hdr_len(r);
    d = pos - hl;
    tens = r.order / 6'h0a;
    ones = r.order % 6'h0a;
    pct = r.dtype == mrf_pkg::EFFICIENCY_TYPE
      || r.dtype == mrf_pkg::MOTOR_EFFICIENCY_TYPE
      || r.dtype == mrf_pkg::TOTAL_EFFICIENCY_TYPE;
    dg = r.dtype == mrf_pkg::HARMONIC_VOLTAGE_PHASE_TYPE
      || r.dtype == mrf_pkg::HARMONIC_CURRENT_PHASE_TYPE;
    ph = (r.phase == mrf_pkg::PH_LAG) ? mrf_pkg::CH_G
      : (r.phase == mrf_pkg::PH_LEAD) ? mrf_pkg::CH_D : mrf_pkg::CH_SPACE;
    case (r.expo)
      mrf_pkg::EXP_MILLI: ex = mrf_pkg::EXP_M3;
      mrf_pkg::EXP_UNIT: ex = mrf_pkg::EXP_P0;
      mrf_pkg::EXP_KILO: ex = mrf_pkg::EXP_P3;
      default: ex = mrf_pkg::EXP_P6;
    endcase
    b = mrf_pkg::CH_SPACE;
    if (pos == 5'h00) begin
      b = mrf_pkg::CH_COMMA;
    end else if (pos <= 5'h03) begin
      b = r.dtype[8 * (3 - pos) +: 8];
    end else if (pos == 5'h04) begin
      if (r.element != 3'h0)
        b = mrf_pkg::CH_ZERO + {5'h00, r.element};
    end else if (pos == 5'h05) begin
      case (r.state)
        mrf_pkg::ST_NORMAL: b = mrf_pkg::CH_N;
        mrf_pkg::ST_OVERRANGE: b = mrf_pkg::CH_I;
        mrf_pkg::ST_OVERFLOW: b = mrf_pkg::CH_O;
        mrf_pkg::ST_PEAK: b = mrf_pkg::CH_P;
        default: b = mrf_pkg::CH_E;
      endcase
    end else if (pos <= hl) begin
      if (!r.harmonic) begin
        if (r.dtype == mrf_pkg::PHASE_ANGLE_TYPE) b = ph;
      end else if (r.order != 6'h00 && pos == 5'h06) begin
        b = mrf_pkg::CH_ZERO + {4'h0, tens[3:0]};
      end else if (r.order != 6'h00 && pos == 5'h07) begin
        b = mrf_pkg::CH_ZERO + {4'h0, ones[3:0]};
      end else if (pos == 5'h08 && dg && r.order == 6'h01) begin
        b = ph;
      end
    end else if (!r.harmonic
        && r.dtype == mrf_pkg::ELAPSED_INTEG_TIME_TYPE) begin
      // Hours, minutes, seconds as hhh:mm:ss, tail padded
      case (d)
        5'h01, 5'h02, 5'h03: b = mant_char(r, d);
        5'h04, 5'h07: b = mrf_pkg::CH_COLON;
        5'h05, 5'h06: b = mant_char(r, d - 5'h01);
        5'h08, 5'h09: b = mant_char(r, d - 5'h02);
        default: b = mrf_pkg::CH_SPACE;
      endcase
    end else if (r.state == mrf_pkg::ST_OVERRANGE
        || r.state == mrf_pkg::ST_NODATA) begin
      b = mrf_pkg::OVR_DATA[8 * (11 - d) +: 8];
    end else if (d == 5'h01) begin
      b = r.negative ? mrf_pkg::CH_MINUS : mrf_pkg::CH_SPACE;
    end else if (d <= 5'h08) begin
      b = mant_char(r, d - 5'h01);
    end else if (pct) begin
      b = (d == 5'h09) ? mrf_pkg::CH_PERCENT : mrf_pkg::CH_SPACE;
    end else begin
      b = ex[8 * (11 - d) +: 8];
    end
    return b;
  endfunction : rec_byte

  // ----------------------------------------------------------------
  // State and configuration
  // ----------------------------------------------------------------
  mrf_fsm_t state_reg, state_next;
  mrf_pkg::mrf_layout_t layout_reg, layout_next;
  mrf_pkg::mrf_rec_t rec_reg, rec_next;
  logic [3:0] line_reg, line_next;
  logic [3:0] slot_reg, slot_next;
  logic [4:0] idx_reg, idx_next;
  logic first_reg, first_next;
  logic end_reg, end_next;
  logic three_reg, three_next;
  logic integ_reg, integ_next;
  logic motor_reg, motor_next;
  logic crlf_reg, crlf_next;
  logic [5:0] maxord_reg, maxord_next;
  logic req_reg, busy_reg, done_reg;
  logic out_v_reg, skid_v_reg;
  logic [7:0] out_d_reg, skid_d_reg;

  // Table lookups for the current line and slot
  wire [6:0] sel_idx = {line_reg - 4'h1, slot_reg[2:0]};
  wire sel_any = |SEL_EN[{line_reg - 4'h1, 3'h0} +: 8];
  wire cur_line_on = line_on(layout_reg, line_reg, three_reg, integ_reg,
    motor_reg, sel_any);
  wire [3:0] cur_slots = slot_count(layout_reg, integ_reg, line_reg);
  wire [3:0] cur_end = end_line(layout_reg, integ_reg);
  wire slot_en = (layout_reg != mrf_pkg::LAYOUT_SEL) || SEL_EN[sel_idx];
  wire [4:0] last_pos = hdr_len(rec_reg) + mrf_pkg::DATA_LEN;
  // Orders past the hard limit or the set maximum are never sent
  wire rec_skip = REC.harmonic && (REC.order > mrf_pkg::MAX_HARM_ORDER
    || REC.order > maxord_reg);
  wire [4:0] term_first = crlf_reg ? 5'h00 : 5'h01;

  // Byte source selection and push into the buffer
  wire buf_ready = !skid_v_reg;
  wire push_valid = state_reg == S_BYTE || state_reg == S_END
    || state_reg == S_TERM;
  wire push = push_valid && buf_ready;
  wire [7:0] term_byte = (idx_reg == 5'h00) ? mrf_pkg::CH_CR : mrf_pkg::CH_LF;
  wire [7:0] end_byte = mrf_pkg::END_WORD[8 * (2 - idx_reg) +: 8];
  wire [7:0] push_byte = (state_reg == S_TERM) ? term_byte
    : (state_reg == S_END) ? end_byte : rec_byte(rec_reg, idx_reg);

  // ----------------------------------------------------------------
  // Block walker
  // ----------------------------------------------------------------
  // Config other than SEL_EN is latched at START so a mid-block change of it cannot tear a block
  always_comb begin
    state_next = state_reg;
    layout_next = layout_reg;
    rec_next = rec_reg;
    line_next = line_reg;
    slot_next = slot_reg;
    idx_next = idx_reg;
    first_next = first_reg;
    end_next = end_reg;
    three_next = three_reg;
    integ_next = integ_reg;
    motor_next = motor_reg;
    crlf_next = crlf_reg;
    maxord_next = maxord_reg;
    case (state_reg)
      S_IDLE: begin
        if (START) begin
          layout_next = LAYOUT;
          three_next = THREE_WIRE;
          integ_next = INTEGRATION_OPTION;
          motor_next = MOTOR_OPTION;
          crlf_next = TERM_CRLF;
          maxord_next = MAX_ORDER;
          line_next = 4'h1;
          end_next = 1'b0;
          state_next = S_LINE;
        end
      end
      S_LINE: begin
        if (line_reg == cur_end) begin
          idx_next = 5'h00;
          state_next = S_END;
        end else if (cur_line_on) begin
          slot_next = 4'h0;
          first_next = 1'b1;
          state_next = S_SLOT;
        end else begin
          line_next = line_reg + 4'h1;
        end
      end
      S_SLOT: begin
        if (slot_reg == cur_slots) begin
          idx_next = term_first;
          state_next = S_TERM;
        end else if (slot_en) begin
          state_next = S_REQ;
        end else begin
          slot_next = slot_reg + 4'h1;
        end
      end
      S_REQ: begin
        if (REC_VALID) begin
          rec_next = REC;
          if (rec_skip) begin
            slot_next = slot_reg + 4'h1;
            state_next = S_SLOT;
          end else begin
            // Comma only before items after the first sent one
            idx_next = first_reg ? 5'h01 : 5'h00;
            state_next = S_BYTE;
          end
        end
      end
      S_BYTE: begin
        if (push) begin
          if (idx_reg == last_pos) begin
            first_next = 1'b0;
            slot_next = slot_reg + 4'h1;
            state_next = S_SLOT;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      S_END: begin
        if (push) begin
          if (idx_reg == 5'h02) begin
            end_next = 1'b1;
            idx_next = term_first;
            state_next = S_TERM;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      S_TERM: begin
        if (push) begin
          if (idx_reg == 5'h01) begin
            line_next = line_reg + 4'h1;
            state_next = end_reg ? S_IDLE : S_LINE;
          end else begin
            idx_next = idx_reg + 5'h01;
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Walker registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_reg <= S_IDLE;
      layout_reg <= mrf_pkg::LAYOUT_SEL;
      rec_reg <= '0;
      line_reg <= 4'h1;
      slot_reg <= 4'h0;
      idx_reg <= 5'h00;
      first_reg <= 1'b1;
      end_reg <= 1'b0;
      three_reg <= 1'b0;
      integ_reg <= 1'b0;
      motor_reg <= 1'b0;
      crlf_reg <= 1'b0;
      maxord_reg <= 6'h00;
      req_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      layout_reg <= layout_next;
      rec_reg <= rec_next;
      line_reg <= line_next;
      slot_reg <= slot_next;
      idx_reg <= idx_next;
      first_reg <= first_next;
      end_reg <= end_next;
      three_reg <= three_next;
      integ_reg <= integ_next;
      motor_reg <= motor_next;
      crlf_reg <= crlf_next;
      maxord_reg <= maxord_next;
      req_reg <= state_next == S_REQ;
      busy_reg <= state_next != S_IDLE;
      done_reg <= state_reg == S_TERM && state_next == S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------
  // The skid entry catches the byte pushed while the receiver stalls
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      out_v_reg <= 1'b0;
      out_d_reg <= 8'h00;
      skid_v_reg <= 1'b0;
      skid_d_reg <= 8'h00;
    end else if (OUT_READY || !out_v_reg) begin
      out_v_reg <= skid_v_reg || push;
      out_d_reg <= skid_v_reg ? skid_d_reg : push_byte;
      skid_v_reg <= 1'b0;
    end else if (push) begin
      skid_v_reg <= 1'b1;
      skid_d_reg <= push_byte;
    end
  end

  assign REQ_VALID = req_reg;
  assign REQ_LINE = line_reg;
  assign REQ_SLOT = slot_reg;
  assign OUT_VALID = out_v_reg;
  assign OUT_DATA = out_d_reg;
  assign BUSY = busy_reg;
  assign DONE = done_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  wire rec_push = push && state_reg == S_BYTE;
  wire [4:0] hl_cur = hdr_len(rec_reg);

  property p_rec_len;
    rec_push && idx_reg == last_pos |-> last_pos == (rec_reg.harmonic
      ? mrf_pkg::HDR_LEN_HARM + mrf_pkg::DATA_LEN : 5'h11);
  endproperty
  a_rec_len: assert property (p_rec_len)
    else $error("record length wrong");

  property p_state_char;
    rec_push && idx_reg == 5'h05 && rec_reg.state == mrf_pkg::ST_PEAK
      |-> push_byte == mrf_pkg::CH_P;
  endproperty
  a_state_char: assert property (p_state_char)
    else $error("state character wrong");

  property p_nodata;
    rec_push && rec_reg.state == mrf_pkg::ST_NODATA && !rec_reg.harmonic
      && rec_reg.dtype != mrf_pkg::ELAPSED_INTEG_TIME_TYPE
      && idx_reg == hl_cur + 5'h02 |-> push_byte == mrf_pkg::CH_NINE;
  endproperty
  a_nodata: assert property (p_nodata)
    else $error("no-data pattern wrong");

  property p_percent;
    rec_push && rec_reg.dtype == mrf_pkg::EFFICIENCY_TYPE
      && rec_reg.state == mrf_pkg::ST_NORMAL && idx_reg == hl_cur + 5'h09
      |-> push_byte == mrf_pkg::CH_PERCENT;
  endproperty
  a_percent: assert property (p_percent)
    else $error("percent sign missing");

  property p_time_colon;
    rec_push && !rec_reg.harmonic
      && rec_reg.dtype == mrf_pkg::ELAPSED_INTEG_TIME_TYPE
      && (idx_reg == 5'h0a || idx_reg == 5'h0d)
      |-> push_byte == mrf_pkg::CH_COLON;
  endproperty
  a_time_colon: assert property (p_time_colon)
    else $error("time colon missing");

  property p_comma;
    rec_push && idx_reg == 5'h00 |-> push_byte == mrf_pkg::CH_COMMA
      && !first_reg;
  endproperty
  a_comma: assert property (p_comma)
    else $error("comma misplaced");

  property p_skip;
    state_reg == S_REQ && REC_VALID && REC.harmonic
      && REC.order > mrf_pkg::MAX_HARM_ORDER
      |=> state_reg == S_SLOT && slot_reg == $past(slot_reg) + 4'h1;
  endproperty
  a_skip: assert property (p_skip)
    else $error("excess order not skipped");

  property p_drop;
    state_reg == S_LINE && layout_reg == mrf_pkg::LAYOUT_SEL && three_reg
      && line_reg == 4'h3 |=> state_reg == S_LINE ##1 line_reg == 4'h5;
  endproperty
  a_drop: assert property (p_drop)
    else $error("three-wire lines not dropped");

  property p_end_word;
    state_reg == S_END && push |-> push_byte == end_byte
      && line_reg == cur_end;
  endproperty
  a_end_word: assert property (p_end_word)
    else $error("END line misplaced");

  property p_hold;
    out_v_reg && !OUT_READY |=> out_v_reg && $stable(out_d_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output dropped under stall");

  c_sel_done: cover property (DONE && layout_reg == mrf_pkg::LAYOUT_SEL);
  c_d2_done: cover property (DONE && layout_reg ==
    mrf_pkg::DEFAULT_LAYOUT_TWO && integ_reg);
  c_stall: cover property (out_v_reg && !OUT_READY ##1 skid_v_reg);
  c_skip: cover property (state_reg == S_REQ && REC_VALID && rec_skip);

endmodule : mrf_formatter

// file: sim/mrf_sink.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Slow byte receiver
// ----------------------------------------------------------------
module mrf_sink (
  input wire logic CLK,
  output logic OUT_READY
);
  int seed = 86829;
  // Random stalls fill the two-entry buffer and back up the walker
  initial begin
    OUT_READY = 1'b0;
    forever begin
      @(negedge CLK);
      OUT_READY = ($random(seed) % 4) != 0;
    end
  end
endmodule : mrf_sink

// file: sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module tb;
  logic clk = 1'b0, nrst = 1'b0, start = 1'b0, three = 1'b0, integ = 1'b0;
  logic motor = 1'b0, crlf = 1'b0, rec_valid = 1'b0, req_valid, out_valid;
  logic out_ready, busy, done;
  logic [5:0] max_order = 6'h32;
  logic [79:0] sel_en = '0;
  logic [3:0] req_line, req_slot;
  logic [7:0] out_data, want;
  logic [7:0] q[$];
  mrf_pkg::mrf_layout_t layout = mrf_pkg::DEFAULT_LAYOUT_ONE;
  mrf_pkg::mrf_rec_t rec = '0;
  int n_fail = 0, cmp_count = 0, cyc = 0, seed = 86828, n_done = 0;

  mrf_formatter u_mrf_formatter (.CLK(clk), .NRST(nrst), .START(start),
    .LAYOUT(layout), .THREE_WIRE(three), .INTEGRATION_OPTION(integ),
    .MOTOR_OPTION(motor), .TERM_CRLF(crlf), .MAX_ORDER(max_order),
    .SEL_EN(sel_en), .REQ_VALID(req_valid), .REQ_LINE(req_line),
    .REQ_SLOT(req_slot), .REC_VALID(rec_valid), .REC(rec),
    .OUT_VALID(out_valid), .OUT_DATA(out_data), .OUT_READY(out_ready),
    .BUSY(busy), .DONE(done));
  mrf_sink u_mrf_sink (.CLK(clk), .OUT_READY(out_ready));

  always #5 clk = ~clk;

  // Each accepted byte is matched against the oldest note
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      want = (q.size() != 0) ? q.pop_front() : 8'hxx;
      `CHK(out_data, want)
    end
  end

  // A hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Expected bytes, built from the record handed to the block
  // ----------------------------------------------------------------
  function automatic void note_rec(mrf_pkg::mrf_rec_t r);
    logic [23:0] exps [4] = '{mrf_pkg::EXP_M3, mrf_pkg::EXP_P0,
      mrf_pkg::EXP_P3, mrf_pkg::EXP_P6};
    logic [7:0] st [5] = '{8'h4e, 8'h49, 8'h4f, 8'h50, 8'h45};
    logic [7:0] ph, el;
    logic [23:0] ex;
    logic [135:0] all;
    ph = r.phase == mrf_pkg::PH_LAG ? 8'h47 :
      r.phase == mrf_pkg::PH_LEAD ? 8'h44 : 8'h20;
    if (r.dtype != mrf_pkg::PHASE_ANGLE_TYPE) ph = 8'h20;
    el = r.element == 3'h0 ? 8'h20 : 8'h30 + r.element;
    ex = exps[r.expo];
    if (r.dtype != 24'h415f5f && r.dtype != mrf_pkg::PHASE_ANGLE_TYPE)
      ex = 24'h252020;
    all = {r.dtype, el, st[r.state], ph, r.negative ? 8'h2d : 8'h20,
      r.mantissa, ex};
    if (r.state == mrf_pkg::ST_OVERRANGE || r.state == mrf_pkg::ST_NODATA)
      all[87:0] = mrf_pkg::OVR_DATA;
    if (r.dtype == mrf_pkg::ELAPSED_INTEG_TIME_TYPE)
      all[87:0] = {r.mantissa[55:32], 8'h3a, r.mantissa[31:16], 8'h3a,
        r.mantissa[15:0], 16'h2020};
    for (int i = 16; i >= 0; i--) q.push_back(all[i*8+:8]);
  endfunction : note_rec

  // Answers one request; a skipped record is an over-order harmonic
  task automatic serve(input int s, input int ln, inout bit f,
    input bit skip);
    logic [23:0] types [4] = '{mrf_pkg::EFFICIENCY_TYPE, 24'h415f5f,
      mrf_pkg::PHASE_ANGLE_TYPE, mrf_pkg::MOTOR_EFFICIENCY_TYPE};
    logic [31:0] rv;
    int w;
    w = 0;
    while (req_valid !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    `CHK(req_slot, 4'(s))
    `CHK(req_line, 4'(ln))
    rv = $random(seed);
    rec.harmonic = skip;
    rec.order = skip ? 6'h3f : 6'h00;
    rec.dtype = (rv[26:25] == 2'h0) ? mrf_pkg::ELAPSED_INTEG_TIME_TYPE
      : types[rv[12:11]];
    rec.element = rv[2:0] > 3'h4 ? 3'h4 : rv[2:0];
    rec.state = mrf_pkg::mrf_state_t'(rv[5:3] > 3'h4 ? 3'h4 : rv[5:3]);
    rec.phase = mrf_pkg::mrf_phase_t'(rv[7:6] == 2'h3 ? 2'h0 : rv[7:6]);
    rec.negative = rv[8];
    rec.expo = mrf_pkg::mrf_exp_t'(rv[10:9]);
    for (int i = 0; i < 7; i++) rec.mantissa[i*8+:8] = 8'h30 + rv[i+13+:3];
    if (f && !skip) q.push_back(8'h2c);
    if (!skip) note_rec(rec);
    f = f || !skip;
    rec_valid = 1'b1;
    @(negedge clk);
    rec_valid = 1'b0;
  endtask : serve

  // One block; plan holds items per line, lowest nibble first
  task automatic run_block(input mrf_pkg::mrf_layout_t lay,
    input logic t, input logic g, input logic c, input logic [39:0] plan,
    input logic [39:0] lines, input logic [79:0] sel);
    int w;
    int d0;
    bit f;
    layout = lay;
    three = t;
    integ = g;
    crlf = c;
    sel_en = sel;
    motor = $random(seed);
    max_order = 6'($random(seed));
    d0 = n_done;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    // Lines nibble gives the line number sent; manual slots follow sel
    while (plan[3:0] != 4'h0) begin
      f = 1'b0;
      for (int s = 0; s < plan[3:0]; s++)
        if (lay != mrf_pkg::LAYOUT_SEL || sel[lines[3:0] * 8 - 8 + s])
          serve(s, lines[3:0], f, lay == mrf_pkg::LAYOUT_SEL && s == 0);
      if (c) q.push_back(8'h0d);
      q.push_back(8'h0a);
      plan = plan >> 4;
      lines = lines >> 4;
    end
    q = {q, 8'h45, 8'h4e, 8'h44};
    if (c) q.push_back(8'h0d);
    q.push_back(8'h0a);
    for (w = 0; q.size() != 0 && w < 3000; w++) @(negedge clk);
    repeat (4) @(negedge clk);
    `CHK(busy, 1'b0)
    `CHK(q.size(), 0)
    `CHK(n_done, d0 + 1)
  endtask : run_block

  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    run_block(mrf_pkg::DEFAULT_LAYOUT_ONE, 0, 0, 0, 40'h13333, 40'h54321,
      '0);
    run_block(mrf_pkg::DEFAULT_LAYOUT_ONE, 1, 0, 1, 40'h1333, 40'h5431,
      '0);
    run_block(mrf_pkg::DEFAULT_LAYOUT_TWO, 0, 0, 0, 40'h12444, 40'h54321,
      '0);
    run_block(mrf_pkg::DEFAULT_LAYOUT_TWO, 1, 0, 1, 40'h1244, 40'h5431,
      '0);
    run_block(mrf_pkg::DEFAULT_LAYOUT_TWO, 0, 1, 1, 40'h171717171,
      40'h987654321, '0);
    run_block(mrf_pkg::DEFAULT_LAYOUT_TWO, 1, 1, 0, 40'h1717171,
      40'h9876521, '0);
    run_block(mrf_pkg::LAYOUT_SEL, 1, 0, 1, 40'h888, 40'h971,
      80'h0001_0042_0800_1001_ff85);
    summarize();
  end
endmodule : tb
